//--- include/pgs_consts.svh
// constants of the polling group scheduler: register offsets, fields, resets, timing
// assumes inclusion by the package and by the design files
`ifndef PGS_CONSTS_SVH
`define PGS_CONSTS_SVH

// register byte offsets
`define PGS_OFF_CTRL      8'h00
`define PGS_OFF_IDLE_LVL  8'h04
`define PGS_OFF_TRIAL_MIN 8'h08
`define PGS_OFF_CMD       8'h0c
`define PGS_OFF_STATUS    8'h10
`define PGS_OFF_GROUP     8'h40

// ctrl field positions
`define PGS_CTRL_BASE 0
`define PGS_CTRL_SYM  1
`define PGS_CTRL_RPT  2
// command field positions
`define PGS_CMD_APPLY  0
`define PGS_CMD_COMMIT 1

// reset values of the configuration
`define PGS_RST_CTRL      3'h1
`define PGS_RST_IDLE_LVL  7'h01
`define PGS_RST_TRIAL_MIN 7'h1e

// legal ranges
`define PGS_IDLE_LVL_MIN  7'h01
`define PGS_IDLE_LVL_MAX  7'h64
`define PGS_TRIAL_MIN_MIN 7'h01
`define PGS_TRIAL_MIN_MAX 7'h78
`define PGS_GROUP_CLOSED  6'h00

// timing
`define PGS_CLK_PERIOD_NS 50
`define PGS_MINUTE_S      60
`define PGS_CLK_HZ        20000000
`define PGS_RESP_WIN_NS   10000

`endif

//--- include/pgs_pkg.sv
// types shared by the polling group scheduler files
// assumes the constants header is on the include path
`include "pgs_consts.svh"

package pgs_pkg;

  // scheduler states, gray coded along sel, poll, wait, base
  typedef enum logic [1:0] {
    PGS_SEL  = 2'b00,
    PGS_POLL = 2'b01,
    PGS_WAIT = 2'b11,
    PGS_BASE = 2'b10
  } pgs_state_e;

  // one configuration set: ctrl bits, idle level, trial minutes
  typedef struct packed {
    logic [2:0] ctrl;
    logic [6:0] idle_lvl;
    logic [6:0] trial_min;
  } pgs_cfg_s;

endpackage

//--- logic/pgs_fifo.sv
// synchronous fifo with valid and ready on both sides
// assumes one clock and a synchronous active-high reset
module pgs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // whole state of the fifo
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } pgs_fifo_s;

  pgs_fifo_s st_q; // registered state
  pgs_fifo_s st_d; // next state
  logic push; // entry written this cycle
  logic pop; // entry drained this cycle

  // honest flags from the fill count
  assign in_ready_o = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_q.cnt != '0);
  assign out_data_o = st_q.mem[st_q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data_i;
      st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

//--- logic/pgs_tick_div.sv
// divider that gives a one-cycle enable pulse every COUNT cycles
// assumes one clock and a synchronous active-high reset
module pgs_tick_div #(
  parameter int COUNT = 1200000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  output logic tick_o
);
  // whole state of the divider
  typedef struct packed {
    logic [30:0] cnt;
    logic tick;
  } pgs_div_s;

  pgs_div_s st_q; // registered state
  pgs_div_s st_d; // next state

  assign tick_o = st_q.tick;

  // count up, wrap and pulse; clear restarts the period
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (clr_i) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == 31'(COUNT - 1)) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

//--- logic/pgs_sched.sv
// polling group scheduler: base polling slots, idle skipping, group forwarding filter
// assumes a classic wishbone master, synchronous inputs, one 20 MHz clock
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
module pgs_sched
  import pgs_pkg::*;
#(
  parameter int NREM = 8,
  parameter int DW = 8,
  parameter int FIFO_DEPTH = 16,
  parameter int MINUTE_CYCLES = `PGS_MINUTE_S * `PGS_CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // slot grants towards the radio
  output logic grant_valid_o,
  output logic grant_base_o,
  output logic [$clog2(NREM)-1:0] grant_id_o,
  input wire logic grant_ready_i,
  // poll answers
  input wire logic resp_valid_i,
  input wire logic resp_nak_i,
  // packets received from remotes
  input wire logic pkt_valid_i,
  output logic pkt_ready_o,
  input wire logic [$clog2(NREM)-1:0] pkt_src_i,
  input wire logic [DW-1:0] pkt_data_i,
  // packets to resend to remotes of one group
  output logic fwd_valid_o,
  input wire logic fwd_ready_i,
  output logic [5:0] fwd_group_o,
  output logic [DW-1:0] fwd_data_o,
  // direct path check between two remotes
  input wire logic [$clog2(NREM)-1:0] chk_a_i,
  input wire logic [$clog2(NREM)-1:0] chk_b_i,
  output logic chk_allow_o,
  // trial state
  output logic trial_active_o
);
  localparam int RW = $clog2(NREM);
  localparam int RESP_CYC_RAW = `PGS_RESP_WIN_NS / `PGS_CLK_PERIOD_NS;
  localparam int RESP_CYC = (RESP_CYC_RAW < 1) ? 1 : RESP_CYC_RAW;

  // state of the block, apart from the repeat buffer and the minute divider
  typedef struct packed {
    pgs_state_e state;
    logic [RW-1:0] idx;
    logic [15:0] win;
    logic [NREM-1:0][5:0] grp;
    logic [NREM-1:0][6:0] skip;
    pgs_cfg_s staged;
    pgs_cfg_s cur;
    pgs_cfg_s stored;
    logic trial;
    logic [6:0] trial_left;
    logic ack;
    logic [31:0] rdat;
    logic allow;
  } pgs_top_s;

  pgs_top_s st_q; // registered state
  pgs_top_s st_d; // next state
  logic min_tick; // one pulse per minute
  logic div_clr; // restarts the minute divider
  logic bus_req; // new wishbone access this cycle
  logic bus_wr; // new write access
  logic [31:0] wmask; // byte-lane write mask
  logic fifo_in_valid; // packet goes into the repeat buffer
  logic fifo_in_ready; // buffer has room
  logic [DW+5:0] fifo_out; // group and data leaving the buffer
  logic is_base; // running as base station
  logic is_sym; // running symmetric policy
  logic is_rpt; // running with repeating on
  logic src_open; // sender has a nonzero group

  assign is_base = st_q.cur.ctrl[`PGS_CTRL_BASE];
  assign is_sym = st_q.cur.ctrl[`PGS_CTRL_SYM];
  assign is_rpt = st_q.cur.ctrl[`PGS_CTRL_RPT];
  assign bus_req = cyc_i && stb_i && !st_q.ack;
  assign bus_wr = bus_req && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // grants are combinational from the state
  assign grant_valid_o = (st_q.state == PGS_POLL) || (st_q.state == PGS_BASE);
  assign grant_base_o = (st_q.state == PGS_BASE);
  assign grant_id_o = st_q.idx;
  assign ack_o = st_q.ack;
  assign dat_o = st_q.rdat;
  assign chk_allow_o = st_q.allow;
  assign trial_active_o = st_q.trial;

  // repeat buffer admission: only open senders while repeating
  assign src_open = (st_q.grp[pkt_src_i] != `PGS_GROUP_CLOSED);
  assign fifo_in_valid = pkt_valid_i && is_base && is_rpt && src_open;
  assign pkt_ready_o = fifo_in_valid ? fifo_in_ready : 1'b1;
  assign fwd_group_o = fifo_out[DW+5:DW];
  assign fwd_data_o = fifo_out[DW-1:0];

  // clamp a written value into its legal range
  function automatic logic [6:0] clamp7(input logic [6:0] v, input logic [6:0] lo,
                                        input logic [6:0] hi);
    logic [6:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // repeat buffer holding group and payload
  pgs_fifo #(
    .WIDTH(DW + 6),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({st_q.grp[pkt_src_i], pkt_data_i}),
    .out_valid_o(fwd_valid_o),
    .out_ready_i(fwd_ready_i),
    .out_data_o(fifo_out)
  );

  // minute enable for the trial countdown
  pgs_tick_div #(
    .COUNT(MINUTE_CYCLES)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(div_clr),
    .tick_o(min_tick)
  );

  // divider restarts whenever a trial starts
  assign div_clr = bus_wr && (adr_i == `PGS_OFF_CMD) && sel_i[0] && dat_i[`PGS_CMD_APPLY];

  // next state of scheduler, configuration and bus
  always_comb begin
    logic advance; // current remote done, move on
    logic wrap; // polling round ends with this move
    logic mark_idle; // current remote just went idle
    logic [31:0] wv; // merged write value
    st_d = st_q;
    advance = 1'b0;
    mark_idle = 1'b0;
    wrap = (st_q.idx == RW'(NREM - 1));
    wv = 32'h0;

    // scheduler
    case (st_q.state)
      PGS_SEL: begin
        if (is_base) begin
          if (st_q.skip[st_q.idx] != 7'h00) begin
            advance = 1'b1;
            // one skipped round counted off each time the remote is passed over
            st_d.skip[st_q.idx] = st_q.skip[st_q.idx] - 1'b1;
            if (wrap && is_sym) begin
              st_d.state = PGS_BASE;
            end
          end else begin
            st_d.state = PGS_POLL;
          end
        end
      end
      PGS_POLL: begin
        if (grant_ready_i) begin
          st_d.state = PGS_WAIT;
          st_d.win = 16'(RESP_CYC - 1);
        end
      end
      PGS_WAIT: begin
        if (resp_valid_i || st_q.win == 16'h0) begin
          mark_idle = !resp_valid_i || resp_nak_i;
          advance = 1'b1;
          if (!is_sym || wrap) begin
            st_d.state = PGS_BASE;
          end else begin
            st_d.state = PGS_SEL;
          end
        end else begin
          st_d.win = st_q.win - 1'b1;
        end
      end
      PGS_BASE: begin
        if (grant_ready_i) begin
          st_d.state = PGS_SEL;
        end
      end
      default: begin
        st_d.state = PGS_SEL;
      end
    endcase

    // index move; an idle remote is skipped exactly idle-level rounds
    if (advance) begin
      st_d.idx = wrap ? '0 : st_q.idx + 1'b1;
    end
    if (mark_idle && is_base) begin
      st_d.skip[st_q.idx] = st_q.cur.idle_lvl;
    end
    if (!is_base) begin
      st_d.skip = '0;
      st_d.state = PGS_SEL;
    end

    // trial countdown and automatic restore
    if (st_q.trial && min_tick) begin
      if (st_q.trial_left == 7'h01) begin
        st_d.cur = st_q.stored;
        st_d.trial = 1'b0;
      end else begin
        st_d.trial_left = st_q.trial_left - 1'b1;
      end
    end

    // direct path between two remotes
    st_d.allow = !is_rpt && (chk_a_i != chk_b_i)
                 && (st_q.grp[chk_a_i] != `PGS_GROUP_CLOSED)
                 && (st_q.grp[chk_a_i] == st_q.grp[chk_b_i]);

    // wishbone: ack one cycle after the request, dropped the next
    st_d.ack = bus_req;
    if (bus_req && !we_i) begin
      if (adr_i == `PGS_OFF_CTRL) begin
        st_d.rdat = {29'h0, st_q.staged.ctrl};
      end else if (adr_i == `PGS_OFF_IDLE_LVL) begin
        st_d.rdat = {25'h0, st_q.staged.idle_lvl};
      end else if (adr_i == `PGS_OFF_TRIAL_MIN) begin
        st_d.rdat = {25'h0, st_q.staged.trial_min};
      end else if (adr_i == `PGS_OFF_STATUS) begin
        st_d.rdat = {1'b0, st_q.trial_left, 1'b0, st_q.cur.trial_min,
                     1'b0, st_q.cur.idle_lvl, st_q.state, st_q.cur.ctrl, 2'b00, st_q.trial};
      end else if (adr_i >= `PGS_OFF_GROUP && adr_i < 8'(`PGS_OFF_GROUP + 4 * NREM)) begin
        st_d.rdat = {26'h0, st_q.grp[RW'((adr_i - `PGS_OFF_GROUP) >> 2)]};
      end else begin
        st_d.rdat = 32'h0; // unmapped and command read as zero
      end
    end else if (bus_wr) begin
      st_d.rdat = 32'h0;
      if (adr_i == `PGS_OFF_CTRL) begin
        wv = (dat_i & wmask) | ({29'h0, st_q.staged.ctrl} & ~wmask);
        st_d.staged.ctrl = wv[2:0];
      end else if (adr_i == `PGS_OFF_IDLE_LVL) begin
        wv = (dat_i & wmask) | ({25'h0, st_q.staged.idle_lvl} & ~wmask);
        st_d.staged.idle_lvl = clamp7(wv[6:0], `PGS_IDLE_LVL_MIN, `PGS_IDLE_LVL_MAX);
      end else if (adr_i == `PGS_OFF_TRIAL_MIN) begin
        wv = (dat_i & wmask) | ({25'h0, st_q.staged.trial_min} & ~wmask);
        st_d.staged.trial_min = clamp7(wv[6:0], `PGS_TRIAL_MIN_MIN, `PGS_TRIAL_MIN_MAX);
      end else if (adr_i == `PGS_OFF_CMD) begin
        if (sel_i[0] && dat_i[`PGS_CMD_APPLY]) begin
          st_d.cur = st_q.staged;
          st_d.trial = 1'b1;
          st_d.trial_left = st_q.staged.trial_min;
          st_d.skip = '0;
          st_d.state = PGS_SEL;
        end else if (sel_i[0] && dat_i[`PGS_CMD_COMMIT]) begin
          st_d.stored = st_q.cur;
          st_d.cur = st_q.cur; // a commit beats a restore in the same cycle
          st_d.trial = 1'b0;
        end
      end else if (adr_i >= `PGS_OFF_GROUP && adr_i < 8'(`PGS_OFF_GROUP + 4 * NREM)) begin
        if (sel_i[0]) begin
          st_d.grp[RW'((adr_i - `PGS_OFF_GROUP) >> 2)] = dat_i[5:0];
        end
      end
    end
  end

  // state register with configuration defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.state <= PGS_SEL;
      st_q.staged <= '{`PGS_RST_CTRL, `PGS_RST_IDLE_LVL, `PGS_RST_TRIAL_MIN};
      st_q.cur <= '{`PGS_RST_CTRL, `PGS_RST_IDLE_LVL, `PGS_RST_TRIAL_MIN};
      st_q.stored <= '{`PGS_RST_CTRL, `PGS_RST_IDLE_LVL, `PGS_RST_TRIAL_MIN};
    end else begin
      st_q <= st_d;
    end
  end
endmodule

//--- testbench/pgs_sched_asserts.sv
// port checker of the polling group scheduler
// assumes it is bound to pgs_sched and sees its ports only
module pgs_sched_asserts #(
  parameter int NREM = 8,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic grant_valid_o,
  input wire logic grant_base_o,
  input wire logic [$clog2(NREM)-1:0] grant_id_o,
  input wire logic grant_ready_i,
  input wire logic resp_valid_i,
  input wire logic pkt_ready_o,
  input wire logic fwd_valid_o,
  input wire logic fwd_ready_i,
  input wire logic [5:0] fwd_group_o,
  input wire logic [DW-1:0] fwd_data_o,
  input wire logic [$clog2(NREM)-1:0] chk_a_i,
  input wire logic [$clog2(NREM)-1:0] chk_b_i,
  input wire logic chk_allow_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wait_q; // a taken remote slot awaits its answer
  logic [8:0] wait_n; // cycles spent in that wait
  // bus traffic may restart polling, so it closes the tracked window
  always_ff @(posedge clk_i) begin
    if (rst_i || (cyc_i && stb_i)) begin
      wait_q <= 1'b0;
      wait_n <= 9'h000;
    end else if (grant_valid_o && grant_ready_i && !grant_base_o) begin
      wait_q <= 1'b1;
      wait_n <= 9'h000;
    end else if (grant_valid_o) begin
      wait_q <= 1'b0;
    end else if (wait_q) begin
      wait_n <= wait_n + 9'h001;
    end
  end
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_GRANT_HOLD: assert property (grant_valid_o && !grant_ready_i && !(cyc_i && stb_i)
    |=> grant_valid_o && $stable({grant_base_o, grant_id_o})) else $error("grant withdrawn");
  AST_POLL_WAIT: assert property (!(cyc_i && stb_i) && grant_valid_o && grant_ready_i &&
    !grant_base_o |=> !grant_valid_o) else $error("no answer window after poll");
  // window of 200 cycles plus one scan over all remotes
  AST_WIN_BOUND: assert property (wait_q |-> wait_n <= 9'd212)
    else $error("answer window too long");
  AST_RESP_NEXT: assert property (wait_q && resp_valid_i && !(cyc_i && stb_i)
    |-> ##[1:12] grant_valid_o) else $error("answer did not end window");
  AST_FULL_ONLY: assert property (!pkt_ready_o |-> fwd_valid_o)
    else $error("refused with empty buffer");
  AST_FWD_HOLD: assert property (fwd_valid_o && !fwd_ready_i
    |=> fwd_valid_o && $stable({fwd_group_o, fwd_data_o})) else $error("repeat lost");
  AST_FWD_OPEN: assert property (fwd_valid_o |-> fwd_group_o != 6'h00)
    else $error("closed remote repeated");
  AST_SAME_REMOTE: assert property (chk_a_i == chk_b_i |=> !chk_allow_o)
    else $error("path to itself allowed");
endmodule
bind pgs_sched pgs_sched_asserts #(.NREM(NREM), .DW(DW)) u_asserts (.clk_i, .rst_i, .cyc_i,
  .stb_i, .ack_o, .grant_valid_o, .grant_base_o, .grant_id_o, .grant_ready_i, .resp_valid_i,
  .pkt_ready_o, .fwd_valid_o, .fwd_ready_i, .fwd_group_o, .fwd_data_o, .chk_a_i, .chk_b_i,
  .chk_allow_o);

//--- testbench/pgs_remote_model.sv
// model of the remote stations: takes slot grants and answers polls
// assumes the scheduler's grant port and one shared clock
module pgs_remote_model (
  input wire logic clk_i,
  input wire logic grant_valid_i,
  input wire logic grant_base_i,
  input wire logic [2:0] grant_id_i,
  input wire logic [7:0] mute_i, // remotes that stay silent
  input wire logic [7:0] nak_i, // remotes that answer negatively
  output logic grant_ready_o,
  output logic resp_valid_o,
  output logic resp_nak_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 69; // fixed seed keeps the stalls repeatable
  int wait_n = -1; // cycles left until the answer, -1 when idle
  logic [2:0] id_q = 3'h0; // remote that was polled
  initial begin
    grant_ready_o = 1'b0;
    resp_valid_o = 1'b0;
    resp_nak_o = 1'b0;
  end
  // take grants after random stalls, answer at a random delay inside the window
  always @(posedge clk_i) begin
    grant_ready_o <= grant_valid_i & 1'($random(seed));
    resp_valid_o <= 1'b0;
    resp_nak_o <= 1'($random(seed)); // meaningless outside an answer
    if (grant_valid_i && grant_ready_o && !grant_base_i) begin
      wait_n <= 1 + ($unsigned($random(seed)) % 120);
      id_q <= grant_id_i;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (wait_n == 0) begin
      wait_n <= -1;
      resp_valid_o <= !mute_i[id_q];
      resp_nak_o <= nak_i[id_q];
    end
  end
endmodule

//--- testbench/test_polling_group_scheduler.sv
// self-checking bench of the polling group scheduler
// assumes the checker and remote model are compiled before it
`include "pgs_consts.svh"
module test_polling_group_scheduler;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, grant_valid_o, grant_base_o, grant_ready_i, resp_valid_i, resp_nak_i;
  logic [2:0] grant_id_o, chk_a_i = 3'h0, chk_b_i = 3'h0, pkt_src_i = 3'h0;
  logic pkt_valid_i = 1'b0, pkt_ready_o, fwd_valid_o, fwd_ready_i = 1'b0;
  logic chk_allow_o, trial_active_o, asym_on = 1'b0, last_rem = 1'b0;
  logic [7:0] pkt_data_i = 8'h00, fwd_data_o;
  logic [5:0] fwd_group_o, grp [8];
  logic [13:0] exp_q [$];
  int seed = 69, error_cnt = 0, tests_run = 0, base_n = 0, rem_n = 0, pn [8];
  always #25 clk_i = ~clk_i;
  // a minute of 100 cycles keeps trials short
  pgs_sched #(.MINUTE_CYCLES(100)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .grant_valid_o, .grant_base_o, .grant_id_o,
    .grant_ready_i, .resp_valid_i, .resp_nak_i, .pkt_valid_i, .pkt_ready_o, .pkt_src_i,
    .pkt_data_i, .fwd_valid_o, .fwd_ready_i, .fwd_group_o, .fwd_data_o, .chk_a_i, .chk_b_i,
    .chk_allow_o, .trial_active_o);
  // remote 5 stays silent, remote 6 answers negatively
  pgs_remote_model u_remote (.clk_i, .grant_valid_i(grant_valid_o), .grant_base_i(grant_base_o),
    .grant_id_i(grant_id_o), .mute_i(8'h20), .nak_i(8'h40), .grant_ready_o(grant_ready_i),
    .resp_valid_o(resp_valid_i), .resp_nak_o(resp_nak_i));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic exp_allow(int a, int b, logic rpt);
    return a != b && grp[a] == grp[b] && grp[a] != 6'h00 && !rpt;
  endfunction
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack wait", 2, n);
  endtask
  // stage a configuration, apply it, optionally commit it; clears the tallies
  task automatic apply(input logic [31:0] c, input logic [31:0] t, input logic keep);
    wb(1, `PGS_OFF_CTRL, c);
    wb(1, `PGS_OFF_TRIAL_MIN, t);
    wb(1, `PGS_OFF_IDLE_LVL, 32'h3);
    wb(1, `PGS_OFF_CMD, 32'h1);
    if (keep) wb(1, `PGS_OFF_CMD, 32'h2);
    base_n = 0;
    rem_n = 0;
    last_rem = 1'b0;
    foreach (pn[i]) pn[i] = 0;
  endtask
  task automatic wait_cond(input int kind, input int k);
    int n;
    n = 0;
    while ((kind == 0 ? pn[0] < k : trial_active_o !== 1'b0) && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    chk("wait", 1, n < 20000);
    wb(0, `PGS_OFF_STATUS, 32'h0);
  endtask
  task automatic check_pairs(input logic rpt);
    for (int a = 0; a < 8; a++) begin
      for (int b = 0; b < 8; b++) begin
        chk_a_i <= 3'(a);
        chk_b_i <= 3'(b);
        repeat (2) @(posedge clk_i);
        chk("direct path", exp_allow(a, b, rpt), chk_allow_o);
      end
    end
  endtask
  // tally slot grants as the radio takes them
  always @(posedge clk_i) begin
    if (!rst_i && grant_valid_o === 1'b1 && grant_ready_i === 1'b1) begin
      if (grant_base_o) base_n++;
      else begin
        pn[grant_id_o]++;
        rem_n++;
        chk("base after remote", 0, asym_on && last_rem);
      end
      last_rem = !grant_base_o;
    end
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    chk("watchdog", 0, 1);
    end_sim();
  end
  initial begin
    logic [7:0] ca [4] = '{8'h04, 8'h04, 8'h08, 8'h08};
    logic [31:0] cw [4] = '{32'h0, 32'h65, 32'h0, 32'h79};
    logic [31:0] ce [4] = '{32'h1, 32'h64, 32'h1, 32'h78};
    logic full;
    int n;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `PGS_OFF_STATUS, 32'h0);
    chk("status", 32'h001e0108, rd & 32'h007f7f39);
    wb(0, 8'h30, 32'h0);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 4; i++) begin
      wb(1, ca[i], cw[i]);
      wb(0, ca[i], 32'h0);
      chk("clamp", ce[i], rd & 32'h7f);
    end
    $display("test registers done");
    foreach (grp[i]) begin
      grp[i] = (i == 1 || i == 2) ? 6'h3f : (i == 7) ? 6'h00 : 6'($unsigned($random(seed)) % 3);
      wb(1, `PGS_OFF_GROUP + 8'(4 * i), 32'(grp[i]));
    end
    check_pairs(1'b0);
    $display("test groups done");
    apply(32'h1, 32'd120, 1'b1);
    chk("trial after commit", 0, trial_active_o);
    asym_on = 1'b1;
    wait_cond(0, 12);
    asym_on = 1'b0;
    chk("silent polls", 1, pn[5] >= 2 && pn[5] <= 5);
    chk("nak polls", 1, pn[6] >= 2 && pn[6] <= 5);
    chk("asym slots", 1, base_n >= rem_n - 1 && base_n <= rem_n);
    $display("test asymmetric done");
    apply(32'h3, 32'd120, 1'b0);
    chk("trial on", 1, trial_active_o);
    wait_cond(0, 4);
    chk("sym slots", 1, base_n >= pn[0] - 1 && base_n <= pn[0] + 1);
    wait_cond(1, 0);
    chk("restored ctrl", 1, (rd >> 3) & 32'h7);
    $display("test symmetric done");
    apply(32'h5, 32'd1, 1'b1);
    wait_cond(1, 0);
    chk("committed ctrl", 5, (rd >> 3) & 32'h7);
    check_pairs(1'b1);
    full = 1'b0;
    pkt_valid_i <= 1'b1;
    for (int i = 0; i < 48 && !full; i++) begin
      pkt_src_i <= 3'($random(seed));
      pkt_data_i <= 8'($random(seed));
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (pkt_ready_o !== 1'b1 && n < 5);
      if (n == 5) full = 1'b1;
      else if (grp[pkt_src_i] != 6'h00) exp_q.push_back({grp[pkt_src_i], pkt_data_i});
    end
    pkt_valid_i <= 1'b0;
    chk("filled", 16, exp_q.size());
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin
      fwd_ready_i <= 1'($random(seed));
      @(posedge clk_i);
      n++;
      if (fwd_valid_o === 1'b1 && fwd_ready_i === 1'b1)
        chk("repeat", exp_q.pop_front(), {fwd_group_o, fwd_data_o});
    end
    fwd_ready_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("drained", 0, fwd_valid_o);
    $display("test repeater done");
    apply(32'h0, 32'd120, 1'b0);
    repeat (60) @(posedge clk_i);
    chk("slots as remote", 0, base_n + rem_n);
    wait_cond(1, 0);
    chk("restored committed ctrl", 5, (rd >> 3) & 32'h7);
    $display("test remote station done");
    end_sim();
  end
endmodule
